//--- hdl/sspe_params.svh
// constants of the serial slave protocol engine
// Overview of operation
// - negative response: stx, station, nak, error code, block check, cr
// - station field carries 01 to 32 as two characters
// - error codes 01h-08h, 11h, 13h, 16h as listed
// - block check is xor of ascii bytes from station to last field
// - characters use standard ascii values, hex digits 30-39 and 41-46
// - ascii broadcast commands get no response
// - rtu query unfinished within trip limit: restart receiver, no response
// - after timeout act on error action setting 00 to 04
// - timeout supervision idle until first traffic, runs only while talking
// - trip limit time 0.00 to 99.99 s is the timeout threshold
// - extra wait 0 to 1000 ms before response, after silent interval; the engine applies it to rtu only, ascii answers at once
// - transmit only in response to a received query
// - rtu accepts only queries to own slave address 1 to 32; ascii answers any station 1 to 32
// - address zero is broadcast to all slaves
// - positive response: stx, station, ack, block check, cr
`ifndef SSPE_PARAMS_SVH
`define SSPE_PARAMS_SVH
`define SSPE_CHR_STX 8'h02
`define SSPE_CHR_ACK 8'h06
`define SSPE_CHR_CR 8'h0d
`define SSPE_CHR_NAK 8'h15
`define SSPE_CHR_ZERO 8'h30
`define SSPE_CHR_A_OFS 8'h37
`define SSPE_STATION_MIN 8'h01
`define SSPE_STATION_MAX 8'h20
`define SSPE_BCAST_RTU 8'h00
`define SSPE_BCAST_ASCII 8'hff
`define SSPE_ERR_PARITY 8'h01
`define SSPE_ERR_SUM 8'h02
`define SSPE_ERR_FRAMING 8'h03
`define SSPE_ERR_OVERRUN 8'h04
`define SSPE_ERR_PROTOCOL 8'h05
`define SSPE_ERR_ASCII 8'h06
`define SSPE_ERR_BUFOVF 8'h07
`define SSPE_ERR_TIMEOUT 8'h08
`define SSPE_ERR_COMMAND 8'h11
`define SSPE_ERR_EXEC 8'h13
`define SSPE_ERR_PARAM 8'h16
`define SSPE_CLK_HZ 40000000
`define SSPE_TRIP_MAX_CS 14'd9999
`define SSPE_WAIT_MAX_MS 11'd1000
`define SSPE_TICK_10MS_NS 10000000
`define SSPE_TICK_1MS_NS 1000000
`define SSPE_CLK_NS 25
`define SSPE_CYC_10MS (`SSPE_TICK_10MS_NS / `SSPE_CLK_NS)
`define SSPE_CYC_1MS (`SSPE_TICK_1MS_NS / `SSPE_CLK_NS)
`endif

//--- hdl/sspe_pkg.sv
// types of the serial slave protocol engine
package sspe_pkg;
    typedef enum logic [7:0] {
        SSPE_IDLE = 8'h01,
        SSPE_STX = 8'h02,
        SSPE_ST_HI = 8'h04,
        SSPE_ST_LO = 8'h08,
        SSPE_CTRL = 8'h10,
        SSPE_ERR_HI = 8'h20,
        SSPE_ERR_LO = 8'h40,
        SSPE_TAIL = 8'h80
    } sspe_tx_state_t;
    typedef enum logic [2:0] {
        SSPE_ACT_TRIP = 3'h0,
        SSPE_ACT_DECEL_TRIP = 3'h1,
        SSPE_ACT_IGNORE = 3'h2,
        SSPE_ACT_FREE_RUN = 3'h3,
        SSPE_ACT_DECEL = 3'h4
    } sspe_action_t;
endpackage

//--- hdl/sspe_tick_timer.sv
// prescaled down counter used for trip limit and response wait
`timescale 1ns/100ps
`default_nettype none
module sspe_tick_timer #(
    parameter int PRESCALE = 400000,
    parameter int CW = 14
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic start,
    input wire logic stop,
    input wire logic [CW-1:0] limit,
    output logic running,
    output logic expired
);
    logic [31:0] pre;
    logic [CW-1:0] ticks;
    logic [31:0] next_pre;
    logic [CW-1:0] next_ticks;
    logic next_running;
    logic next_expired;

    always_comb begin
        next_pre = pre;
        next_ticks = ticks;
        next_running = running;
        next_expired = 1'b0;
        if (start) begin
            next_pre = 32'h0;
            next_ticks = limit;
            next_running = 1'b1;
        end else if (stop) begin
            next_running = 1'b0;
        end else if (running) begin
            if (ticks == '0) begin
                next_running = 1'b0;
                next_expired = 1'b1;
            end else if (pre == 32'(PRESCALE - 1)) begin
                next_pre = 32'h0;
                next_ticks = ticks - 1'b1;
            end else begin
                next_pre = pre + 32'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pre <= 32'h0;
            ticks <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else if (clk_en) begin
            pre <= next_pre;
            ticks <= next_ticks;
            running <= next_running;
            expired <= next_expired;
        end
    end
endmodule // sspe_tick_timer
`default_nettype wire

//--- hdl/sspe_engine.sv
// slave protocol engine: ascii responses, rtu addressing and timeouts
`include "sspe_params.svh"
`timescale 1ns/100ps
`default_nettype none
module sspe_engine
    import sspe_pkg::*;
#(
    parameter int CYC_10MS = `SSPE_CYC_10MS,
    parameter int CYC_1MS = `SSPE_CYC_1MS
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic rtu_mode,
    input wire logic [7:0] own_address,
    input wire logic ascii_frame_done,
    input wire logic [7:0] ascii_station,
    input wire logic ascii_ok,
    input wire logic ascii_parity_err,
    input wire logic ascii_framing_err,
    input wire logic ascii_sum_err,
    input wire logic ascii_command_err,
    input wire logic [7:0] ascii_other_err,
    input wire logic rtu_rx_active,
    input wire logic rtu_query_done,
    input wire logic [7:0] rtu_address,
    input wire logic rtu_tx_done,
    input wire logic [2:0] comm_error_action_select,
    input wire logic [13:0] comm_trip_limit_time,
    input wire logic [10:0] comm_response_wait_time,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic rtu_accept,
    output logic rtu_broadcast,
    output logic rtu_respond,
    output logic rtu_rx_restart,
    output logic comm_timeout_trip_fault,
    output logic decel_stop_req,
    output logic free_run_stop
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    sspe_tx_state_t state, next_state;
    logic [7:0] station, next_station;
    logic [7:0] err_code, next_err_code;
    logic is_nak, next_is_nak;
    logic [7:0] xor_block_check, next_xor_block_check;
    logic [1:0] tail, next_tail;
    logic [7:0] next_tx_data;
    logic next_tx_valid;
    logic [7:0] chr;
    logic addressed, next_addressed;
    logic armed, next_armed;
    logic wait_pend, next_wait_pend;
    logic [7:0] first_err;
    logic trip_exp;
    logic wait_exp;
    logic trip_run;
    logic next_trip_fault, next_decel, next_free_run_stop;

    function automatic logic [7:0] hex_chr(input logic [3:0] n);
        hex_chr = (n < 4'ha) ? (`SSPE_CHR_ZERO + {4'h0, n})
                             : (`SSPE_CHR_A_OFS + {4'h0, n});
    endfunction

    // parity outranks framing, sum and command checks
    always_comb begin
        if (ascii_parity_err) first_err = `SSPE_ERR_PARITY;
        else if (ascii_framing_err) first_err = `SSPE_ERR_FRAMING;
        else if (ascii_sum_err) first_err = `SSPE_ERR_SUM;
        else if (ascii_command_err) first_err = `SSPE_ERR_COMMAND;
        else first_err = ascii_other_err;
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        next_station = station;
        next_err_code = err_code;
        next_is_nak = is_nak;
        next_xor_block_check = xor_block_check;
        next_tail = tail;
        next_tx_data = tx_data;
        next_tx_valid = tx_valid;
        chr = 8'h00;
        case (state)
            SSPE_IDLE: begin
                next_tx_valid = 1'b0;
                // broadcast and out of range stations stay silent
                if (ascii_frame_done && !rtu_mode &&
                    ascii_station >= `SSPE_STATION_MIN &&
                    ascii_station <= `SSPE_STATION_MAX) begin
                    next_station = ascii_station;
                    next_is_nak = !ascii_ok;
                    next_err_code = first_err;
                    next_xor_block_check = 8'h00;
                    next_tx_data = `SSPE_CHR_STX;
                    next_tx_valid = 1'b1;
                    next_state = SSPE_STX;
                end
            end
            SSPE_STX, SSPE_ST_HI, SSPE_ST_LO, SSPE_CTRL,
            SSPE_ERR_HI, SSPE_ERR_LO: begin
                if (tx_ready) begin
                    // stx stays outside the block check
                    if (state != SSPE_STX) begin
                        next_xor_block_check =
                            xor_block_check ^ tx_data;
                    end
                    case (state)
                        SSPE_STX: chr = hex_chr(4'(station / 8'd10));
                        SSPE_ST_HI: chr = hex_chr(4'(station % 8'd10));
                        SSPE_ST_LO: chr = is_nak ? `SSPE_CHR_NAK
                                                 : `SSPE_CHR_ACK;
                        SSPE_CTRL: chr = is_nak ?
                            hex_chr(err_code[7:4]) :
                            hex_chr(next_xor_block_check[7:4]);
                        SSPE_ERR_HI: chr = hex_chr(err_code[3:0]);
                        default: chr = hex_chr(next_xor_block_check[7:4]);
                    endcase
                    next_tx_data = chr;
                    case (state)
                        SSPE_STX: next_state = SSPE_ST_HI;
                        SSPE_ST_HI: next_state = SSPE_ST_LO;
                        SSPE_ST_LO: next_state = SSPE_CTRL;
                        SSPE_CTRL: next_state = is_nak ? SSPE_ERR_HI
                                                       : SSPE_TAIL;
                        SSPE_ERR_HI: next_state = SSPE_ERR_LO;
                        default: next_state = SSPE_TAIL;
                    endcase
                    // the high check digit is already out: tail opens low
                    next_tail = 2'd1;
                end
            end
            SSPE_TAIL: begin
                if (tx_ready) begin
                    // tail 1: low check digit next, 2: cr, 3: done
                    if (tail == 2'd1) begin
                        next_tx_data = hex_chr(xor_block_check[3:0]);
                        next_tail = 2'd2;
                    end else if (tail == 2'd2) begin
                        next_tx_data = `SSPE_CHR_CR;
                        next_tail = 2'd3;
                    end else begin
                        next_tx_valid = 1'b0;
                        next_state = SSPE_IDLE;
                    end
                end
            end
            default: begin
                next_state = SSPE_IDLE;
                next_tx_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= SSPE_IDLE;
            station <= 8'h00;
            err_code <= 8'h00;
            is_nak <= 1'b0;
            xor_block_check <= 8'h00;
            tail <= 2'd0;
            tx_data <= 8'h00;
            tx_valid <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            station <= next_station;
            err_code <= next_err_code;
            is_nak <= next_is_nak;
            xor_block_check <= next_xor_block_check;
            tail <= next_tail;
            tx_data <= next_tx_data;
            tx_valid <= next_tx_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rtu addressing, wait and timeout supervision
    assign rtu_broadcast = rtu_mode && rtu_query_done &&
        (rtu_address == `SSPE_BCAST_RTU);
    assign addressed = rtu_mode && rtu_query_done &&
        (rtu_address == own_address) &&
        (own_address >= `SSPE_STATION_MIN) &&
        (own_address <= `SSPE_STATION_MAX);

    always_comb begin
        next_armed = armed;
        next_wait_pend = wait_pend;
        next_addressed = 1'b0;
        next_trip_fault = comm_timeout_trip_fault;
        next_decel = decel_stop_req;
        next_free_run_stop = free_run_stop;
        if (rtu_mode && (rtu_rx_active || rtu_query_done))
            next_armed = 1'b1;
        if (wait_pend && wait_exp) begin
            next_wait_pend = 1'b0;
            next_addressed = 1'b1;
        end
        // a new query in the expiry cycle must keep its own wait
        if (addressed) next_wait_pend = 1'b1;
        if (trip_exp) begin
            case (comm_error_action_select)
                SSPE_ACT_TRIP: next_trip_fault = 1'b1;
                SSPE_ACT_DECEL_TRIP: begin
                    next_decel = 1'b1;
                    next_trip_fault = 1'b1;
                end
                SSPE_ACT_FREE_RUN: next_free_run_stop = 1'b1;
                SSPE_ACT_DECEL: next_decel = 1'b1;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            armed <= 1'b0;
            wait_pend <= 1'b0;
            rtu_respond <= 1'b0;
            comm_timeout_trip_fault <= 1'b0;
            decel_stop_req <= 1'b0;
            free_run_stop <= 1'b0;
        end else if (clk_en) begin
            armed <= next_armed;
            wait_pend <= next_wait_pend;
            rtu_respond <= next_addressed;
            comm_timeout_trip_fault <= next_trip_fault;
            decel_stop_req <= next_decel;
            free_run_stop <= next_free_run_stop;
        end
    end

    assign rtu_accept = addressed;
    assign rtu_rx_restart = trip_exp;

    // trip limit counted in 10 ms steps, restarted by each response end after first traffic
    sspe_tick_timer #(.PRESCALE(CYC_10MS), .CW(14)) u_trip (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .start(rtu_mode && armed && rtu_tx_done),
        .stop(rtu_query_done || !rtu_mode),
        .limit(comm_trip_limit_time > `SSPE_TRIP_MAX_CS ?
            `SSPE_TRIP_MAX_CS : comm_trip_limit_time),
        .running(trip_run),
        .expired(trip_exp)
    );

    sspe_tick_timer #(.PRESCALE(CYC_1MS), .CW(11)) u_wait (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .start(addressed),
        .stop(1'b0),
        .limit(comm_response_wait_time > `SSPE_WAIT_MAX_MS ?
            `SSPE_WAIT_MAX_MS : comm_response_wait_time),
        .running(),
        .expired(wait_exp)
    );

    ////////////////////////////////////////////////////////////////////////
    AST_NO_TX_UNPROMPTED: assert property (
        (clk_en && state == SSPE_IDLE && !ascii_frame_done) |=> !tx_valid)
        else $error("transmit started without a query");
    AST_STX_FIRST: assert property (
        $rose(tx_valid) |-> tx_data == `SSPE_CHR_STX)
        else $error("frame did not open with stx");
    AST_BCAST_SILENT: assert property (
        (clk_en && state == SSPE_IDLE && ascii_frame_done &&
         ascii_station == `SSPE_BCAST_ASCII) |=> !tx_valid)
        else $error("answered an ascii broadcast");
    AST_RTU_ADDR: assert property (
        rtu_accept |-> (rtu_address == own_address && !rtu_broadcast))
        else $error("accepted a foreign or broadcast query");
    AST_TIMEOUT_RESTART: assert property (
        trip_exp |-> rtu_rx_restart && !rtu_respond)
        else $error("timeout did not restart receiver");
    AST_TRIP_ACTION: assert property (
        (clk_en && trip_exp && comm_error_action_select == 3'h0)
        |=> comm_timeout_trip_fault)
        else $error("trip action not taken");
    AST_IGNORE_ACTION: assert property (
        (clk_en && trip_exp && comm_error_action_select == 3'h2 &&
         !comm_timeout_trip_fault) |=> !comm_timeout_trip_fault)
        else $error("ignore action tripped");
    AST_NOT_ARMED: assert property (
        !armed |-> !trip_run)
        else $error("supervision ran before first communication");
    AST_WAIT_FIRST: assert property (
        (clk_en && addressed) |=> !rtu_respond)
        else $error("responded without the wait");
    AST_CR_LAST: assert property (
        $fell(tx_valid) |-> $past(tx_data) == `SSPE_CHR_CR)
        else $error("frame did not end in cr");
    COV_NAK: cover property (state == SSPE_ERR_LO && tx_ready);
    COV_ACK: cover property (state == SSPE_CTRL && !is_nak && tx_ready);
    COV_RTU: cover property (rtu_respond);
    COV_TIMEOUT: cover property (trip_exp);
endmodule // sspe_engine
`default_nettype wire

//--- bench/sspe_master_model.sv
// master-side model: byte sink for the ascii responses of the engine
`timescale 1ns/100ps
`default_nettype none
module sspe_master_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic [7:0] got [$];
    logic [1:0] phase;
    initial begin
        tx_ready = 1'b0;
        phase = 2'h0;
    end
    // slow mode takes one byte in four edges, so each byte must stand
    always @(negedge sys_clk) begin
        phase <= phase + 2'h1;
        tx_ready <= !reset && (!slow || phase == 2'h3);
    end
    always @(posedge sys_clk) begin
        if (!reset && tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
    end
endmodule // sspe_master_model
`default_nettype wire

//--- bench/serial_slave_protocol_engine_tb.sv
// self-checking testbench of the serial slave protocol engine
`include "sspe_params.svh"
`timescale 1ns/100ps
`default_nettype none
module serial_slave_protocol_engine_tb;
    import sspe_pkg::*;
    localparam int C10 = 4;
    localparam int C1 = 2;
    logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, rtu_mode = 1'b0;
    logic [7:0] own_address = 8'h11, ascii_station = 8'h00;
    logic ascii_frame_done = 1'b0, ascii_ok = 1'b0, slow = 1'b0;
    logic [3:0] flg = 4'h0;
    logic [7:0] ascii_other_err = 8'h00, rtu_address = 8'h00;
    logic rtu_rx_active = 1'b0, rtu_query_done = 1'b0, rtu_tx_done = 1'b0;
    logic [2:0] comm_error_action_select = 3'h0;
    logic [13:0] comm_trip_limit_time = 14'h0005;
    logic [10:0] comm_response_wait_time = 11'h003;
    logic tx_ready, tx_valid, rtu_accept, rtu_broadcast, rtu_respond;
    logic rtu_rx_restart, comm_timeout_trip_fault, decel_stop_req;
    logic free_run_stop;
    logic [7:0] tx_data;
    int errors = 0;
    int checks = 0;
    sspe_engine #(.CYC_10MS(C10), .CYC_1MS(C1)) DUT (.sys_clk(sys_clk),
        .reset(reset), .clk_en(clk_en), .rtu_mode(rtu_mode),
        .own_address(own_address), .ascii_frame_done(ascii_frame_done),
        .ascii_station(ascii_station), .ascii_ok(ascii_ok),
        .ascii_parity_err(flg[0]), .ascii_framing_err(flg[1]),
        .ascii_sum_err(flg[2]), .ascii_command_err(flg[3]),
        .ascii_other_err(ascii_other_err), .rtu_rx_active(rtu_rx_active),
        .rtu_query_done(rtu_query_done), .rtu_address(rtu_address),
        .rtu_tx_done(rtu_tx_done),
        .comm_error_action_select(comm_error_action_select),
        .comm_trip_limit_time(comm_trip_limit_time),
        .comm_response_wait_time(comm_response_wait_time),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .rtu_accept(rtu_accept), .rtu_broadcast(rtu_broadcast),
        .rtu_respond(rtu_respond), .rtu_rx_restart(rtu_rx_restart),
        .comm_timeout_trip_fault(comm_timeout_trip_fault),
        .decel_stop_req(decel_stop_req), .free_run_stop(free_run_stop));
    sspe_master_model sink (.sys_clk(sys_clk), .reset(reset), .slow(slow),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask
    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction
    task automatic do_reset();
        reset = 1'b1;
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
    endtask
    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask
    // counts negedges until the selected pulse shows, up to max
    task automatic wait_pulse(input bit rsp, input int max, output int n);
        n = 0;
        while (n < max && !(rsp ? rtu_respond === 1'b1
                                : rtu_rx_restart === 1'b1)) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    task automatic send_ascii(input logic [7:0] st, input logic [3:0] f,
                              input logic [7:0] oth);
        @(negedge sys_clk);
        ascii_frame_done = 1'b1;
        ascii_station = st;
        flg = f;
        ascii_ok = (f == 4'h0) && (oth == 8'h00);
        ascii_other_err = oth;
        @(negedge sys_clk);
        ascii_frame_done = 1'b0;
    endtask
    task automatic check_frame(input logic [7:0] st, input logic [7:0] err);
        logic [7:0] exp [$];
        logic [7:0] xor_block_check;
        int n;
        exp = {`SSPE_CHR_STX, 8'h30 + st / 10, 8'h30 + st % 10};
        if (err == 8'h00) exp.push_back(`SSPE_CHR_ACK);
        else exp = {exp, `SSPE_CHR_NAK, hexc(err[7:4]), hexc(err[3:0])};
        xor_block_check = 8'h00;
        for (int i = 1; i < exp.size(); i++) xor_block_check ^= exp[i];
        exp = {exp, hexc(xor_block_check[7:4]),
               hexc(xor_block_check[3:0]), `SSPE_CHR_CR};
        n = 0;
        while (n < 400 && sink.got.size() < exp.size()) begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        chk(8'(sink.got.size()), 8'(exp.size()), "frame length");
        for (int i = 0; i < exp.size() && i < sink.got.size(); i++)
            chk(sink.got[i], exp[i], "frame byte");
        chk({7'h0, tx_valid}, 8'h00, "valid after cr");
        sink.got.delete();
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({tx_valid, rtu_respond, rtu_rx_restart, comm_timeout_trip_fault,
             decel_stop_req, free_run_stop, 2'b00}, 8'h00, "reset outputs");
        $display("test reset done");
    endtask
    task automatic t_ascii_pos();
        slow = 1'b1;
        send_ascii(8'd5, 4'h0, 8'h00);
        check_frame(8'd5, 8'h00);
        slow = 1'b0;
        send_ascii(8'd1, 4'h0, 8'h00);
        check_frame(8'd1, 8'h00);
        send_ascii(8'd12, 4'h0, 8'h00);
        check_frame(8'd12, 8'h00);
        $display("test ascii positive done");
    endtask
    task automatic t_ascii_neg();
        logic [3:0] f [11] = '{4'h3, 4'h2, 4'hc, 4'h8, 4'h0, 4'h0, 4'h0,
                               4'h0, 4'h0, 4'h0, 4'h0};
        logic [7:0] o [11] = '{8'h05, 8'h00, 8'h00, 8'h04, 8'h04, 8'h05,
                               8'h06, 8'h07, 8'h08, 8'h13, 8'h16};
        logic [7:0] e [11] = '{8'h01, 8'h03, 8'h02, 8'h11, 8'h04, 8'h05,
                               8'h06, 8'h07, 8'h08, 8'h13, 8'h16};
        for (int i = 0; i < 11; i++) begin
            send_ascii(8'd32 - 8'(i), f[i], o[i]);
            check_frame(8'd32 - 8'(i), e[i]);
        end
        $display("test ascii negative done");
    endtask
    task automatic t_ascii_none();
        logic [7:0] st [4] = '{8'hff, 8'h00, 8'd33, 8'd7};
        int seen;
        seen = 0;
        for (int i = 0; i < 4; i++) begin
            rtu_mode = (i == 3);
            send_ascii(st[i], 4'h0, 8'h00);
            repeat (30) begin
                @(negedge sys_clk);
                if (tx_valid !== 1'b0) seen++;
            end
        end
        rtu_mode = 1'b0;
        chk(8'(seen), 8'h00, "unexpected response");
        $display("test ascii silent done");
    endtask
    task automatic t_rtu_addr();
        logic [7:0] a [3] = '{8'h11, 8'h09, 8'h00};
        int n;
        rtu_mode = 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(negedge sys_clk);
            rtu_query_done = 1'b1;
            rtu_address = a[i]; // broadcast is no read
            #1;
            chk({7'h0, rtu_accept}, 8'(i == 0), "accept");
            chk({7'h0, rtu_broadcast}, 8'(i == 2), "broadcast");
            @(negedge sys_clk);
            rtu_query_done = 1'b0;
            // a frozen engine must not let the wait run on
            if (i == 0) begin
                clk_en = 1'b0;
                repeat (10) @(negedge sys_clk);
                clk_en = 1'b1;
            end
            wait_pulse(1'b1, 60, n);
            chk(8'(n < 60), 8'(i == 0), "respond seen");
            if (i == 0)
                chk(8'(n >= 3 * C1), 8'h01, "wait too short");
        end
        $display("test rtu addressing done");
    endtask
    task automatic t_timeout();
        int n;
        rtu_mode = 1'b1;
        for (int act = 0; act < 5; act++) begin
            comm_error_action_select = 3'(act);
            do_reset();
            pulse(rtu_tx_done);
            wait_pulse(1'b0, 60, n);
            chk(8'(n), 8'd60, "supervision before first traffic");
            pulse(rtu_rx_active);
            pulse(rtu_tx_done);
            repeat (8) @(negedge sys_clk);
            rtu_address = 8'h09;
            pulse(rtu_query_done);
            wait_pulse(1'b0, 60, n);
            chk(8'(n), 8'd60, "timer not stopped by query");
            pulse(rtu_tx_done);
            wait_pulse(1'b0, 200, n);
            chk(8'(n < 200), 8'h01, "restart missing");
            chk(8'(n >= 4 * C10), 8'h01, "restart too early");
            repeat (2) @(negedge sys_clk);
            chk({5'h0, comm_timeout_trip_fault, decel_stop_req,
                 free_run_stop}, (act < 2) ? {5'h0, 1'b1, act == 1, 1'b0}
                 : {6'h0, act == 4, act == 3}, "action");
        end
        $display("test timeout actions done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        finish_test();
    end
    initial begin
        do_reset();
        t_reset();
        t_ascii_pos();
        t_ascii_neg();
        t_ascii_none();
        t_rtu_addr();
        t_timeout();
        finish_test();
    end
endmodule // serial_slave_protocol_engine_tb
`default_nettype wire
